// ==== src/rdf_chain.sv ====
// Strobed register access and the register offsets are this design's own decisions.
`timescale 1ns/100ps
module rdf_chain #(
  parameter int NCH = 4,
  parameter int DW = 16,
  parameter int OW = 24
) (
  // Clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // Register port
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  // Straps
  input wire logic pin_control,
  input wire logic strap_master,
  input wire logic [1:0] strap_filter,
  input wire logic [3:0] strap_rate,
  // Modulator samples
  input wire logic mod_valid,
  input wire logic [NCH*DW-1:0] mod_data,
  // Rate strobe pin
  input wire logic output_rate_strobe_i,
  output logic output_rate_strobe_o,
  output logic output_rate_strobe_oe,
  // Results
  output logic [NCH*OW-1:0] sample_data,
  output logic sample_valid,
  output logic [NCH-1:0] settled,
  output logic pll_lock
);
  import rdf_pkg::*;
  localparam int AW = DW + 30;

  logic soft_q;
  logic srst;
  logic master_q;
  logic [23:0] per_int_q;
  logic [15:0] per_frac_q;
  logic [3*NCH-1:0] filt_q;
  logic master;
  logic [23:0] pin_int;
  logic [39:0] cfg_period;
  logic [39:0] est_q;
  logic [39:0] period;
  logic [3:0] il;
  logic [39:0] sub_period;
  logic [39:0] ph_q;
  logic [39:0] ph_inc;
  logic rate_ok;
  logic rs_hit;
  logic rs_evt_q;
  logic [15:0] ovs;
  logic [9:0] dec_q;
  logic [9:0] dec_last;
  logic odr_evt;
  logic strobe_prev_q;
  logic strobe_edge;
  logic [23:0] mcnt_q;
  logic first_q;
  logic timeout;
  logic signed [40:0] err;
  logic [40:0] err_abs;
  logic err_small;
  logic [40:0] est_n;
  logic lock_q;
  logic [3:0] good_q;
  logic [39:0] per_last_q;
  logic mode_last_q;
  logic [NCH-1:0] cfg_err;
  logic [NCH-1:0] settled_w;

  assign srst = !rst_n || soft_q;

  // The restart bit is reloaded from the write every cycle and reset by the pin reset only, so it lasts a cycle.
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      soft_q <= 1'b0;
    end else begin
      soft_q <= reg_wr && reg_addr == ADDR_CTRL && reg_wdata[CTRL_SOFT_RESET_BIT];
    end
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      master_q <= CTRL_MASTER_RESET;
      per_int_q <= PER_INT_RESET;
      per_frac_q <= PER_FRAC_RESET;
      filt_q <= '0;
    end else if (reg_wr) begin
      case (reg_addr)
        ADDR_CTRL: master_q <= reg_wdata[CTRL_MASTER_BIT];
        ADDR_PER_INT: per_int_q <= reg_wdata[23:0];
        ADDR_PER_FRAC: per_frac_q <= reg_wdata[15:0];
        ADDR_FILT: filt_q <= reg_wdata[3*NCH-1:0];
        default: ;
      endcase
    end
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      reg_rdata <= '0;
    end else if (reg_rd) begin
      case (reg_addr)
        ADDR_CTRL: reg_rdata <= 32'({master_q, 1'b0});
        ADDR_PER_INT: reg_rdata <= 32'(per_int_q);
        ADDR_PER_FRAC: reg_rdata <= 32'(per_frac_q);
        ADDR_FILT: reg_rdata <= 32'(filt_q);
        ADDR_STATUS: reg_rdata <= 32'({il, settled_w, |cfg_err, lock_q});
        ADDR_EST: reg_rdata <= 32'(est_q[39:16]);
        default: reg_rdata <= '0;
      endcase
    end else begin
      reg_rdata <= '0;
    end
  end

  // Ratio source: straps or registers in master, the loop estimate in slave.
  assign master = pin_control ? strap_master : master_q;
  assign pin_int = PIN_PER_BASE << strap_rate;
  assign cfg_period = pin_control ? {pin_int, 16'h0000} : {per_int_q, per_frac_q};
  assign period = master ? cfg_period : est_q;

  always_comb begin
    if (period <= P_750K) begin
      il = 4'h3;
    end else if (period <= P_375K) begin
      il = 4'h4;
    end else if (period <= P_367) begin
      il = 4'h5;
    end else begin
      il = 4'ha;
    end
  end

  // Phase accumulator runs at the modulator rate and fires at interp x rate.
  assign sub_period = period >> il;
  assign rate_ok = sub_period >= ONE_SAMPLE;
  assign ph_inc = ph_q + ONE_SAMPLE;
  assign rs_hit = mod_valid && rate_ok && ph_inc >= sub_period;
  assign ovs = 16'(ph_inc - sub_period);

  always_ff @(posedge clock) begin
    if (srst || !rate_ok) begin
      ph_q <= '0;
      rs_evt_q <= 1'b0;
    end else begin
      rs_evt_q <= rs_hit;
      if (mod_valid) begin
        ph_q <= rs_hit ? ph_inc - sub_period : ph_inc;
      end
    end
  end

  assign dec_last = 10'((11'h1 << il) - 11'h1);
  assign odr_evt = rs_evt_q && dec_q >= dec_last;

  always_ff @(posedge clock) begin
    if (srst) begin
      dec_q <= '0;
    end else if (rs_evt_q) begin
      dec_q <= odr_evt ? 10'h000 : dec_q + 10'h001;
    end
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      output_rate_strobe_o <= 1'b0;
      output_rate_strobe_oe <= 1'b0;
      sample_valid <= 1'b0;
    end else begin
      output_rate_strobe_o <= master && odr_evt;
      output_rate_strobe_oe <= master;
      sample_valid <= odr_evt;
    end
  end

  // Slave loop: period measured between rising edges, smoothed by a shift.
  assign strobe_edge = !master && output_rate_strobe_i && !strobe_prev_q;
  assign err = $signed({1'b0, mcnt_q, 16'h0000}) - $signed({1'b0, est_q});
  assign err_abs = err[40] ? 41'(-err) : 41'(err);
  assign err_small = err_abs < {1'b0, LOCK_TOL};
  assign est_n = 41'({1'b0, est_q}) + 41'(err >>> EST_SHIFT);
  assign timeout = !first_q && (mcnt_q > {est_q[38:16], 1'b0} || &mcnt_q);

  always_ff @(posedge clock) begin
    if (srst || master) begin
      strobe_prev_q <= 1'b0;
      mcnt_q <= '0;
      first_q <= 1'b1;
      est_q <= '0;
    end else begin
      strobe_prev_q <= output_rate_strobe_i;
      if (strobe_edge) begin
        mcnt_q <= mod_valid ? 24'h000001 : 24'h000000;
        first_q <= 1'b0;
        est_q <= first_q ? {mcnt_q, 16'h0000} : est_n[39:0];
      end else if (timeout) begin
        first_q <= 1'b1;
        est_q <= '0;
      end else if (mod_valid && !(&mcnt_q)) begin
        mcnt_q <= mcnt_q + 24'h000001;
      end
    end
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      lock_q <= 1'b0;
      good_q <= '0;
      per_last_q <= '0;
      mode_last_q <= 1'b0;
    end else if (master != mode_last_q || (master && cfg_period != per_last_q)) begin
      lock_q <= 1'b0;
      good_q <= '0;
      mode_last_q <= master;
      per_last_q <= cfg_period;
    end else if (master) begin
      if (odr_evt && !lock_q) begin
        lock_q <= good_q == LOCK_EDGES - 4'h1;
        good_q <= good_q + 4'h1;
      end
    end else if (timeout) begin
      lock_q <= 1'b0;
      good_q <= '0;
    end else if (strobe_edge && !first_q) begin
      if (!err_small) begin
        lock_q <= 1'b0;
        good_q <= '0;
      end else if (!lock_q) begin
        lock_q <= good_q == LOCK_EDGES - 4'h1;
        good_q <= good_q + 4'h1;
      end
    end
  end

  assign pll_lock = lock_q;
  assign settled = settled_w;

  for (genvar c = 0; c < NCH; c++) begin : g_ch
    rdf_filt_t ftype;
    rdf_filt_t ftype_q;
    logic ord6;
    logic [5:0] sh;
    logic [3:0] set_lim;
    logic [3:0] set_q;
    logic signed [DW-1:0] x;
    logic signed [DW-1:0] last_q;
    logic signed [DW:0] dif;
    logic signed [DW+17:0] prod;
    logic signed [DW+17:0] yfull;
    logic signed [DW-1:0] rsd_q;
    logic signed [AW-1:0] integ_q [6];
    logic signed [AW-1:0] dly_q [6];
    logic signed [AW-1:0] cs [7];
    logic signed [AW-1:0] cic_full;
    logic signed [OW-1:0] cic_o;
    logic signed [OW-1:0] p1_q;
    logic signed [OW-1:0] p2_q;
    logic signed [OW-1:0] p3_q;
    logic signed [OW+15:0] rej_a;
    logic signed [OW+31:0] rej_b;
    logic signed [OW+3:0] comp;
    logic signed [OW+1:0] avg;
    logic signed [OW-1:0] y;
    logic signed [OW-1:0] data_q;

    assign ftype = pin_control ? rdf_pin_filt(strap_filter)
                               : rdf_filt_t'(filt_q[3*c +: 3]);
    assign ord6 = ftype == rdf_sinc6 || ftype == rdf_wb_wide || ftype == rdf_wb_narrow;

    always_comb begin
      case (ftype)
        rdf_sinc3, rdf_sinc3_rej: cfg_err[c] = period < P_1496K || period > P_10;
        rdf_sinc6: cfg_err[c] = period < P_1496K || period > P_2K5;
        rdf_wb_wide: cfg_err[c] = period < P_374K || period > P_2K5;
        rdf_wb_narrow: cfg_err[c] = pin_control || period < P_374K || period > P_2K5;
        default: cfg_err[c] = 1'b1;
      endcase
    end

    always_comb begin
      case (ftype)
        rdf_sinc3: set_lim = SETTLE_SINC3;
        rdf_sinc3_rej: set_lim = SETTLE_REJ;
        rdf_sinc6: set_lim = SETTLE_SINC6;
        default: set_lim = SETTLE_WB;
      endcase
    end

    // Linear interpolation between neighbours puts nulls at multiples of the modulator rate.
    assign x = mod_data[c*DW +: DW];
    assign dif = (DW+1)'(x) - (DW+1)'(last_q);
    assign prod = (DW+18)'(dif) * (DW+18)'($signed({1'b0, ovs}));
    assign yfull = (DW+18)'(x) - (prod >>> 16);

    always_ff @(posedge clock) begin
      if (srst) begin
        last_q <= '0;
        rsd_q <= '0;
      end else if (mod_valid) begin
        last_q <= x;
        if (rs_hit) begin
          rsd_q <= yfull[DW-1:0];
        end
      end
    end

    // Six integrators always run; sinc3 taps the third and bypasses three combs.
    always_ff @(posedge clock) begin
      if (srst) begin
        for (int k = 0; k < 6; k++) begin
          integ_q[k] <= '0;
        end
      end else if (rs_evt_q) begin
        integ_q[0] <= integ_q[0] + AW'(rsd_q);
        for (int k = 1; k < 6; k++) begin
          integ_q[k] <= integ_q[k] + integ_q[k-1];
        end
      end
    end

    always_comb begin
      cs[0] = ord6 ? integ_q[5] : integ_q[2];
      for (int k = 0; k < 6; k++) begin
        cs[k+1] = (k < 3 || ord6) ? cs[k] - dly_q[k] : cs[k];
      end
    end

    always_ff @(posedge clock) begin
      if (srst) begin
        for (int k = 0; k < 6; k++) begin
          dly_q[k] <= '0;
        end
      end else if (odr_evt) begin
        for (int k = 0; k < 6; k++) begin
          dly_q[k] <= cs[k];
        end
      end
    end

    // Gain is R to the order; removing it keeps 8 guard bits of fraction.
    assign sh = 6'((ord6 ? 6'h06 : 6'h03) * 6'(il) - 6'h08);
    assign cic_full = cs[6] >>> sh;
    assign cic_o = cic_full[OW-1:0];

    always_ff @(posedge clock) begin
      if (srst) begin
        p1_q <= '0;
        p2_q <= '0;
        p3_q <= '0;
      end else if (odr_evt) begin
        p1_q <= cic_o;
        p2_q <= p1_q;
        p3_q <= p2_q;
      end
    end

    // At 50 SPS, 60 Hz folds to 10 Hz; a zero pair there is the extra notch.
    assign rej_a = (OW+16)'(cic_o) + (OW+16)'(p2_q)
                 - (((OW+16)'(p1_q) * (OW+16)'(REJ_C1)) >>> 14);
    assign rej_b = ((OW+32)'(rej_a) * (OW+32)'(REJ_GAIN)) >>> 14;
    // Droop compensation flattens the sinc6 core for the rdf_wb_wide path; rdf_wb_narrow uses the four-sample average.
    assign comp = ((OW+4)'(p1_q) * (OW+4)'(10) - (OW+4)'(cic_o)
                 - (OW+4)'(p2_q)) >>> 3;
    assign avg = ((OW+2)'(cic_o) + (OW+2)'(p1_q) + (OW+2)'(p2_q)
                 + (OW+2)'(p3_q)) >>> 2;

    always_comb begin
      case (ftype)
        rdf_sinc3_rej: y = rej_b[OW-1:0];
        rdf_wb_wide: y = comp[OW-1:0];
        rdf_wb_narrow: y = avg[OW-1:0];
        default: y = cic_o;
      endcase
    end

    always_ff @(posedge clock) begin
      if (srst) begin
        data_q <= '0;
      end else if (odr_evt) begin
        data_q <= y;
      end
    end

    // Counts whole output periods since the last disturbance.
    always_ff @(posedge clock) begin
      if (srst) begin
        set_q <= '0;
        ftype_q <= rdf_sinc3;
      end else begin
        ftype_q <= ftype;
        if (!lock_q || cfg_err[c] || ftype != ftype_q) begin
          set_q <= '0;
        end else if (odr_evt && set_q < set_lim) begin
          set_q <= set_q + 4'h1;
        end
      end
    end

    assign settled_w[c] = set_q >= set_lim;
    assign sample_data[c*OW +: OW] = data_q;
  end
endmodule

// ==== src/rdf_pkg.sv ====
package rdf_pkg;

  localparam longint MOD_RATE_HZ = 64'd24000000;

  // Periods are modulator samples per output sample, 24.16 fixed point.
  function automatic logic [39:0] rdf_per(input longint odr_msps);
    return 40'((MOD_RATE_HZ * 64'd65536000) / odr_msps);
  endfunction

  localparam logic [39:0] P_1496K = rdf_per(64'd1496000000);
  localparam logic [39:0] P_750K = rdf_per(64'd750000000);
  localparam logic [39:0] P_375K = rdf_per(64'd375000000);
  localparam logic [39:0] P_374K = rdf_per(64'd374000000);
  localparam logic [39:0] P_367 = rdf_per(64'd366990);
  localparam logic [39:0] P_2K5 = rdf_per(64'd2500000);
  localparam logic [39:0] P_10 = rdf_per(64'd10000);
  localparam logic [39:0] ONE_SAMPLE = 40'h00_0001_0000;

  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_PER_INT = 8'h04;
  localparam logic [7:0] ADDR_PER_FRAC = 8'h08;
  localparam logic [7:0] ADDR_FILT = 8'h0c;
  localparam logic [7:0] ADDR_STATUS = 8'h10;
  localparam logic [7:0] ADDR_EST = 8'h14;
  localparam int CTRL_SOFT_RESET_BIT = 0;
  localparam int CTRL_MASTER_BIT = 1;
  localparam logic CTRL_MASTER_RESET = 1'b1;
  localparam logic [23:0] PER_INT_RESET = 24'h000080;
  localparam logic [15:0] PER_FRAC_RESET = 16'h0000;
  localparam logic [23:0] PIN_PER_BASE = 24'h000010;

  localparam logic [39:0] LOCK_TOL = 40'h00_0002_0000;
  localparam logic [3:0] LOCK_EDGES = 4'h8;
  localparam int EST_SHIFT = 3;

  localparam logic [3:0] SETTLE_SINC3 = 4'h4;
  localparam logic [3:0] SETTLE_REJ = 4'h6;
  localparam logic [3:0] SETTLE_SINC6 = 4'h7;
  localparam logic [3:0] SETTLE_WB = 4'h9;

  // Q14: 2*cos(2*pi*10/50) and the inverse of the notch's dc gain.
  localparam logic signed [15:0] REJ_C1 = 16'sh278e;
  localparam logic signed [15:0] REJ_GAIN = 16'sh2e4f;

  typedef enum logic [2:0] {
    rdf_sinc3, rdf_sinc3_rej, rdf_sinc6, rdf_wb_wide, rdf_wb_narrow
  } rdf_filt_t;

  function automatic rdf_filt_t rdf_pin_filt(input logic [1:0] s);
    case (s)
      2'h0: return rdf_wb_wide;
      2'h1: return rdf_sinc6;
      2'h2: return rdf_sinc3;
      default: return rdf_sinc3_rej;
    endcase
  endfunction
endpackage

// ==== tb/rdf_chain_chk.sv ====
`timescale 1ns/100ps
module rdf_chk import rdf_pkg::*; #(
  parameter int NCH = 4,
  parameter int DW = 16,
  parameter int OW = 24
) (
  // Clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // Register port
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [31:0] reg_rdata,
  // Straps
  input wire logic pin_control,
  input wire logic strap_master,
  input wire logic [1:0] strap_filter,
  input wire logic [3:0] strap_rate,
  // Modulator samples
  input wire logic mod_valid,
  input wire logic [NCH*DW-1:0] mod_data,
  // Rate strobe pin
  input wire logic output_rate_strobe_i,
  input wire logic output_rate_strobe_o,
  input wire logic output_rate_strobe_oe,
  // Results
  input wire logic [NCH*OW-1:0] sample_data,
  input wire logic sample_valid,
  input wire logic [NCH-1:0] settled,
  input wire logic pll_lock
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);

  logic soft_seen_q;
  logic [23:0] per_seen_q;

  // Shadow of the integer period, so that only a real change is expected to drop lock.
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      soft_seen_q <= 1'b0;
      per_seen_q <= PER_INT_RESET;
    end else begin
      soft_seen_q <= reg_wr && reg_addr == ADDR_CTRL && reg_wdata[CTRL_SOFT_RESET_BIT];
      if (soft_seen_q) begin
        per_seen_q <= PER_INT_RESET;
      end else if (reg_wr && reg_addr == ADDR_PER_INT) begin
        per_seen_q <= reg_wdata[23:0];
      end
    end
  end

  chk_strobe_pairs: assert property (output_rate_strobe_o |-> sample_valid)
    else $error("strobe pulse without a sample");
  chk_strobe_single: assert property (output_rate_strobe_o |=> !output_rate_strobe_o)
    else $error("strobe pulse longer than one cycle");
  chk_slave_quiet: assert property (!output_rate_strobe_oe |-> !output_rate_strobe_o)
    else $error("strobe driven while pin is an input");
  chk_valid_single: assert property (sample_valid |=> !sample_valid)
    else $error("sample valid longer than one cycle");
  chk_data_holds: assert property (
    !sample_valid && !$past(reg_wr) && !$past(reg_wr, 2) |-> $stable(sample_data))
    else $error("sample data moved between samples");
  chk_reset_clear: assert property (@(posedge clock) disable iff (1'b0)
    !rst_n |=> !pll_lock && !output_rate_strobe_oe && !sample_valid)
    else $error("outputs not cleared by reset");
  chk_soft_clear: assert property (
    reg_wr && reg_addr == ADDR_CTRL && reg_wdata[CTRL_SOFT_RESET_BIT] |-> ##3 !pll_lock)
    else $error("lock kept through soft reset");
  chk_period_unlock: assert property (
    reg_wr && reg_addr == ADDR_PER_INT && !pin_control && output_rate_strobe_oe
    && reg_wdata[23:0] != per_seen_q |-> ##3 !pll_lock)
    else $error("lock kept through a period change");
  chk_oe_follows: assert property (
    reg_wr && reg_addr == ADDR_CTRL && !pin_control && !reg_wdata[CTRL_SOFT_RESET_BIT]
    |-> ##2 output_rate_strobe_oe == $past(reg_wdata[CTRL_MASTER_BIT], 2))
    else $error("pin direction does not follow mode");
  chk_rdata_quiet: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0000_0000)
    else $error("read data outside its cycle");

  cover property ($rose(pll_lock) && output_rate_strobe_oe);
  cover property ($rose(pll_lock) && !output_rate_strobe_oe);
  cover property ($rose(settled[0]));
endmodule

bind rdf_chain rdf_chk #(.NCH(NCH), .DW(DW), .OW(OW)) rdf_chk_i (
  .clock(clock), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .pin_control(pin_control),
  .strap_master(strap_master), .strap_filter(strap_filter), .strap_rate(strap_rate),
  .mod_valid(mod_valid), .mod_data(mod_data), .output_rate_strobe_i(output_rate_strobe_i),
  .output_rate_strobe_o(output_rate_strobe_o), .output_rate_strobe_oe(output_rate_strobe_oe),
  .sample_data(sample_data), .sample_valid(sample_valid), .settled(settled),
  .pll_lock(pll_lock));

// ==== tb/rdf_host_model.sv ====
`timescale 1ns/100ps
module rdf_host_model (
  // Clock
  input wire logic clock,
  // Control from the bench
  input wire logic run,
  input wire logic [15:0] period,
  // Rate strobe drive
  output logic strobe
);
  logic [15:0] cnt_q;

  // While run is high the strobe never pauses, so the loop always has edges to track.
  always_ff @(posedge clock) begin
    if (!run || cnt_q >= period - 16'h0001) begin
      cnt_q <= 16'h0000;
    end else begin
      cnt_q <= cnt_q + 16'h0001;
    end
  end

  // A square wave; a period cut below the count mid-cycle wraps at once instead of counting up to the top.
  assign strobe = run && (cnt_q < (period >> 1));
endmodule

// ==== tb/test_resampler_decimation_filter_chain.sv ====
`timescale 1ns/100ps
module test_resampler_decimation_filter_chain;
  import rdf_pkg::*;
  localparam logic [15:0] DC = 16'h1000;
  logic clock, rst_n, reg_wr, reg_rd, pin_control, strap_master, mod_valid;
  logic [7:0] reg_addr;
  logic [31:0] reg_wdata, reg_rdata, d;
  logic [1:0] strap_filter;
  logic [3:0] strap_rate, settled;
  logic [63:0] mod_data;
  logic [95:0] sample_data;
  logic pin, host_strobe, strobe_o, strobe_oe, sample_valid, pll_lock, host_run;
  logic [15:0] host_period;
  int failures, n_checks, n;

  rdf_chain rdf_chain_i (.clock(clock), .rst_n(rst_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .pin_control(pin_control), .strap_master(strap_master), .strap_filter(strap_filter),
    .strap_rate(strap_rate), .mod_valid(mod_valid), .mod_data(mod_data),
    .output_rate_strobe_i(pin), .output_rate_strobe_o(strobe_o),
    .output_rate_strobe_oe(strobe_oe), .sample_data(sample_data),
    .sample_valid(sample_valid), .settled(settled), .pll_lock(pll_lock));
  rdf_host_model rdf_host_model_i (.clock(clock), .run(host_run), .period(host_period),
    .strobe(host_strobe));
  assign pin = (strobe_oe === 1'b1) ? strobe_o : host_strobe;

  always #50 clock = ~clock;

  task chk(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      failures++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task final_report;
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  task cyc(input int k);
    repeat (k) @(posedge clock);
    #1;
  endtask
  task wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge clock);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= v;
    @(posedge clock);
    reg_wr <= 1'b0;
  endtask
  task rd(input logic [7:0] a);
    @(posedge clock);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clock);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask
  task wait_lock(input logic want, input int lim);
    for (int i = 0; i < lim && pll_lock !== want; i++) cyc(1);
  endtask
  // Cycles between two strobe pulses; the first pulse seen only starts the count.
  task gap;
    for (int i = 0; i < 70000 && strobe_o !== 1'b1; i++) cyc(1);
    cyc(1);
    n = 1;
    while (strobe_o !== 1'b1 && n < 70000) begin
      cyc(1);
      n++;
    end
  endtask
  function automatic logic [31:0] rep(input logic [2:0] f);
    return {20'h00000, f, f, f, f};
  endfunction

  task t_reset;
    rd(ADDR_CTRL); chk(d, 32'h0000_0002);
    rd(ADDR_PER_INT); chk(d, 32'h0000_0080);
    rd(ADDR_PER_FRAC); chk(d, 32'h0000_0000);
    wr(8'h20, 32'hffff_ffff);
    rd(8'h20); chk(d, 32'h0000_0000);
  endtask
  task t_master(input logic [23:0] per, input logic [3:0] lg);
    wr(ADDR_PER_INT, {8'h00, per});
    cyc(3); chk(pll_lock, 1'b0);
    gap; gap; chk(n, per);
    chk(strobe_oe, 1'b1);
    wait_lock(1'b1, 20 * per); chk(pll_lock, 1'b1);
    rd(ADDR_STATUS); chk(d[0], 1'b1);
    chk(d[9:6], lg);
  endtask
  task t_ranges;
    wr(ADDR_FILT, rep(3'h2)); wr(ADDR_PER_INT, 32'h0000_2800);
    cyc(3); rd(ADDR_STATUS); chk(d[1], 1'b1);
    wr(ADDR_FILT, rep(3'h3)); wr(ADDR_PER_INT, 32'h0000_0040);
    cyc(3); rd(ADDR_STATUS); chk(d[1], 1'b1);
    wr(ADDR_PER_INT, 32'h0000_0020);
    cyc(3); rd(ADDR_STATUS); chk(d[9:6], 4'h3);
    wr(ADDR_PER_INT, 32'h0001_0000);
    cyc(3); rd(ADDR_STATUS); chk(d[9:6], 4'ha);
  endtask
  task t_filters;
    logic [3:0] s [5];
    logic signed [31:0] e;
    s = '{SETTLE_SINC3, SETTLE_REJ, SETTLE_SINC6, SETTLE_WB, SETTLE_WB};
    for (int f = 0; f < 5; f++) begin
      wr(ADDR_FILT, rep(f[2:0]));
      // The settle count only clears one edge after the type change, so poll after that.
      cyc(2);
      n = 2;
      while (settled !== 4'hf && n < 3000) begin
        cyc(1);
        n++;
      end
      chk(settled, 4'hf);
      chk(n >= (s[f] - 1) * 128 && n <= (s[f] + 1) * 128, 1'b1);
      rd(ADDR_STATUS); chk(d[1], 1'b0);
      for (int i = 0; i < 300 && sample_valid !== 1'b1; i++) cyc(1);
      chk(sample_valid, 1'b1);
      for (int c = 0; c < 4; c++) begin
        e = $signed(sample_data[c*24 +: 24]) - $signed({DC, 8'h00});
        chk(e >= -32'sd1024 && e <= 32'sd1024, 1'b1);
      end
    end
  endtask
  task t_soft;
    wr(ADDR_PER_INT, 32'h0000_0040);
    wr(ADDR_CTRL, 32'h0000_0003);
    cyc(3); chk(pll_lock, 1'b0);
    rd(ADDR_PER_INT); chk(d, 32'h0000_0080);
    rd(ADDR_CTRL); chk(d, 32'h0000_0002);
  endtask
  task t_slave;
    wr(ADDR_CTRL, 32'h0000_0000);
    cyc(3); chk(strobe_oe, 1'b0);
    @(posedge clock);
    host_run <= 1'b1;
    wait_lock(1'b1, 3000); chk(pll_lock, 1'b1);
    rd(ADDR_EST); chk(d >= 99 && d <= 101, 1'b1);
    @(posedge clock);
    host_period <= 16'd60;
    wait_lock(1'b0, 300); chk(pll_lock, 1'b0);
    wait_lock(1'b1, 3000); chk(pll_lock, 1'b1);
    @(posedge clock);
    host_run <= 1'b0;
    wait_lock(1'b0, 400); chk(pll_lock, 1'b0);
  endtask
  task t_pin;
    @(posedge clock);
    pin_control <= 1'b1;
    strap_master <= 1'b1;
    strap_rate <= 4'h2;
    strap_filter <= 2'h2;
    gap; gap; chk(n, 64);
    chk(strobe_oe, 1'b1);
    @(posedge clock);
    strap_master <= 1'b0;
    cyc(4); chk(strobe_oe, 1'b0);
    @(posedge clock);
    pin_control <= 1'b0;
  endtask

  initial begin
    clock = 1'b0; rst_n = 1'b0; reg_wr = 1'b0; reg_rd = 1'b0; reg_addr = 8'h00;
    reg_wdata = 32'h0; pin_control = 1'b0; strap_master = 1'b0; strap_filter = 2'h0;
    strap_rate = 4'h0; mod_valid = 1'b0; mod_data = 64'h0; host_run = 1'b0;
    host_period = 16'd100; failures = 0; n_checks = 0;
    repeat (4) @(posedge clock);
    rst_n <= 1'b1;
    mod_valid <= 1'b1;
    mod_data <= {4{DC}};
    t_reset;
    t_master(24'h80, 4'h5);
    t_master(24'h40, 4'h4);
    t_ranges;
    t_master(24'h80, 4'h5);
    t_filters;
    t_soft;
    t_slave;
    t_pin;
    final_report;
  end

  initial begin
    #6000000;
    failures++;
    final_report;
  end
endmodule
